// File: core/tkp_pkg.sv
// Purpose: Shared constants and types of the timekeeper block
// Assumes: Byte-wide register map, 5-bit byte address
// Notes:   Status busy bit positions equal sync slots 0 to 3; slot 4 shows at tick status bit 0
package tkp_pkg;
   // ----------------------------------------------------------------
   // Bus geometry and register offsets
   // ----------------------------------------------------------------
   localparam int        ADR_W        = 5;
   localparam int        DAT_W        = 8;
   localparam logic [4:0] OFS_CTRL    = 5'h00;
   localparam logic [4:0] OFS_STAT    = 5'h01;
   localparam logic [4:0] OFS_IRQ_EN  = 5'h02;
   localparam logic [4:0] OFS_IRQ_FLG = 5'h03;
   localparam logic [4:0] OFS_LATCH   = 5'h04;
   localparam logic [4:0] OFS_DBG     = 5'h05;
   localparam logic [4:0] OFS_SRC     = 5'h07;
   localparam logic [4:0] OFS_CNT_LO  = 5'h08;
   localparam logic [4:0] OFS_CNT_HI  = 5'h09;
   localparam logic [4:0] OFS_TOP_LO  = 5'h0A;
   localparam logic [4:0] OFS_TOP_HI  = 5'h0B;
   localparam logic [4:0] OFS_MAT_LO  = 5'h0C;
   localparam logic [4:0] OFS_MAT_HI  = 5'h0D;
   localparam logic [4:0] OFS_TCTRL   = 5'h10;
   localparam logic [4:0] OFS_TSTAT   = 5'h11;
   localparam logic [4:0] OFS_TIRQ_EN = 5'h12;
   localparam logic [4:0] OFS_TIRQ_FL = 5'h13;
   localparam logic [4:0] OFS_TDBG    = 5'h15;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ON_BIT    = 0;
   localparam int CTRL_PRESC_LSB = 3;
   localparam int CTRL_STBY_BIT  = 7;
   localparam int TCTRL_ON_BIT   = 0;
   localparam int TCTRL_PER_LSB  = 3;
   localparam int FLG_WRAP       = 0;
   localparam int FLG_MATCH      = 1;
   // Sync slots, also status busy bits
   localparam int SY_CTRL = 0;
   localparam int SY_CNT  = 1;
   localparam int SY_TOP  = 2;
   localparam int SY_MAT  = 3;
   localparam int SY_TICK = 4;
   localparam int SY_N    = 5;
   // ----------------------------------------------------------------
   // Reset values, timing, vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] TOP_RESET      = 16'hFFFF;
   localparam logic [1:0]  SYNC_TICKS     = 2'h2;
   localparam logic [4:0]  SLOW_DIV_LAST  = 5'h1F;
   localparam int          EVT_TOP_LOG2   = 13;
   localparam logic [3:0]  TPER_MIN       = 4'h1;
   localparam logic [3:0]  TPER_MAX       = 4'hE;
   localparam logic [7:0]  VEC_TIMEKEEPER = 8'h00;
   localparam logic [7:0]  VEC_TICK       = 8'h02;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_SLOW_OSC,
      SRC_SLOW_DIV,
      SRC_WATCH_XTAL,
      SRC_PIN
   } tkp_src_t;
   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic       sel;
      logic [4:0] adr;
      logic [7:0] dat;
   } tkp_wb_req_t;
   typedef struct packed {
      logic       ack;
      logic [7:0] dat;
   } tkp_wb_rsp_t;
   typedef struct packed {
      logic       wrap;
      logic       match;
      logic [7:0] tick;
   } tkp_evt_t;
endpackage

// File: core/tkp_edge_sync.sv
// Purpose: Two-flop synchroniser plus rising-edge pulse per lane
// Assumes: Lanes are slow square waves from outside the domain
// Notes:   Edge detect reads only the second and third flops
module tkp_edge_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         rst_n_in,
   // Lanes
   input  wire logic [W-1:0] lane_in,
   output logic      [W-1:0] rise_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] last_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end
      else
      begin
         meta_q <= lane_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise_out = sync_q & ~last_q;
endmodule

// File: core/tkp_timekeeper.sv
// Purpose: 16-bit timekeeper counter with periodic tick timer
// Assumes: Timekeeping sources are slow pins sampled on clk_sys_in
// Notes:   Byte-wide classic Wishbone slave, one wait state per access
//
// How it works
// - One source selection feeds both functions
// - Counter runs while on bit is one
// - Tick timer runs while its on bit set
// - Events only while the function is enabled
// - Wrap event when counter passes top value
// - Match event when counter equals match value
// - Eight tick events, 8192 down to 64
// - Vector 0x00 counter, 0x02 tick timer
// - Tick interrupt each selected period elapsed
// - Flags set regardless of interrupt enables
// - Request while flag and enable both set
// - Counter runs idle; standby needs run bit
// - Tick timer runs in every sleep mode
// - Control, count, top, match and tick control writes take effect after timekeeping ticks
// - Status busy bits: match, top, count, control
// - Tick status bit 0 busy on tick control write
// - Prescaler divides by two to field value
// - Source field picks slow, slow/32, crystal, pin
// - Writing one clears a flag, zero keeps
// - Wrap clears counter; events on following count
//
// Register access over Wishbone is this design's own decision.
module tkp_timekeeper (
   // Clock and reset
   input  wire logic                clk_sys_in,
   input  wire logic                rst_n_in,
   // Register bus
   input  wire tkp_pkg::tkp_wb_req_t wb_req_in,
   output tkp_pkg::tkp_wb_rsp_t      wb_rsp_out,
   // Timekeeping sources
   input  wire logic                slow_internal_osc_in,
   input  wire logic                watch_crystal_osc_in,
   input  wire logic                crystal_input_pin_in,
   // Power and debug state
   input  wire logic                sleep_standby_in,
   input  wire logic                cpu_halted_in,
   // Interrupts and events
   output logic                     irq_timekeeper_out,
   output logic                     irq_tick_out,
   output logic [7:0]               irq_vector_out,
   output tkp_pkg::tkp_evt_t         evt_out
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   tkp_pkg::tkp_wb_rsp_t rsp_q;
   tkp_pkg::tkp_evt_t    evt_q;
   logic [7:0]  ctrl_q, ctrl_act_q, latch_q, rd_dat;
   logic [1:0]  irq_en_q, flag_q;
   logic        dbg_q, tdbg_q, tirq_en_q, tflag_q;
   logic [1:0]  src_q;
   logic [15:0] cnt_q, cnt_wr_q, top_q, top_act_q, mat_q, mat_act_q;
   logic [7:0]  tctrl_q, tctrl_act_q;
   logic [1:0]  sync_cnt_q [tkp_pkg::SY_N];
   logic [tkp_pkg::SY_N-1:0] sync_wr, busy, commit;
   logic [14:0] presc_q, presc_mask, tick_cnt_q;
   logic [15:0] tper_mask;
   logic [4:0]  slow_div_q;
   logic [2:0]  rise;
   logic [7:0]  tick_evt;
   logic        irq_tk_q, irq_tick_q;
   logic [7:0]  vec_q;
   logic        req, wr, rd, src_tick, run, step, wrap_hit, match_hit;
   logic        trun, tirq_hit;
   logic [3:0]  tper;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   assign req = wb_req_in.cyc & wb_req_in.stb & ~rsp_q.ack;
   assign wr  = req & wb_req_in.we & wb_req_in.sel;
   assign rd  = req & ~wb_req_in.we;

   always_comb
   begin
      rd_dat = 8'h00;
      case (wb_req_in.adr)
         tkp_pkg::OFS_CTRL:    rd_dat = ctrl_q;
         tkp_pkg::OFS_STAT:    rd_dat = {4'h0, busy[3:0]};
         tkp_pkg::OFS_IRQ_EN:  rd_dat = {6'h00, irq_en_q};
         tkp_pkg::OFS_IRQ_FLG: rd_dat = {6'h00, flag_q};
         tkp_pkg::OFS_LATCH:   rd_dat = latch_q;
         tkp_pkg::OFS_DBG:     rd_dat = {7'h00, dbg_q};
         tkp_pkg::OFS_SRC:     rd_dat = {6'h00, src_q};
         tkp_pkg::OFS_CNT_LO:  rd_dat = cnt_q[7:0];
         tkp_pkg::OFS_TOP_LO:  rd_dat = top_q[7:0];
         tkp_pkg::OFS_MAT_LO:  rd_dat = mat_q[7:0];
         tkp_pkg::OFS_CNT_HI,
         tkp_pkg::OFS_TOP_HI,
         tkp_pkg::OFS_MAT_HI:  rd_dat = latch_q;
         tkp_pkg::OFS_TCTRL:   rd_dat = tctrl_q;
         tkp_pkg::OFS_TSTAT:   rd_dat = {7'h00, busy[tkp_pkg::SY_TICK]};
         tkp_pkg::OFS_TIRQ_EN: rd_dat = {7'h00, tirq_en_q};
         tkp_pkg::OFS_TIRQ_FL: rd_dat = {7'h00, tflag_q};
         tkp_pkg::OFS_TDBG:    rd_dat = {7'h00, tdbg_q};
         default:              rd_dat = 8'h00;
      endcase
   end

   // Unmapped addresses still ack, reading zero
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rsp_q <= '0;
      else
      begin
         rsp_q.ack <= req;
         rsp_q.dat <= rd ? rd_dat : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Plain registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_q    <= 8'h00;
         irq_en_q  <= 2'h0;
         dbg_q     <= 1'b0;
         src_q     <= 2'h0;
         tctrl_q   <= 8'h00;
         tirq_en_q <= 1'b0;
         tdbg_q    <= 1'b0;
         top_q     <= tkp_pkg::TOP_RESET;
         mat_q     <= 16'h0000;
         cnt_wr_q  <= 16'h0000;
      end
      else if (wr)
      begin
         case (wb_req_in.adr)
            tkp_pkg::OFS_CTRL:    ctrl_q    <= {wb_req_in.dat[7:3], 2'h0, wb_req_in.dat[0]};
            tkp_pkg::OFS_IRQ_EN:  irq_en_q  <= wb_req_in.dat[1:0];
            tkp_pkg::OFS_DBG:     dbg_q     <= wb_req_in.dat[0];
            tkp_pkg::OFS_SRC:     src_q     <= wb_req_in.dat[1:0];
            tkp_pkg::OFS_TCTRL:   tctrl_q   <= {1'b0, wb_req_in.dat[6:3], 2'h0, wb_req_in.dat[0]};
            tkp_pkg::OFS_TIRQ_EN: tirq_en_q <= wb_req_in.dat[0];
            tkp_pkg::OFS_TDBG:    tdbg_q    <= wb_req_in.dat[0];
            tkp_pkg::OFS_CNT_HI:  cnt_wr_q  <= {wb_req_in.dat, latch_q};
            tkp_pkg::OFS_TOP_HI:  top_q     <= {wb_req_in.dat, latch_q};
            tkp_pkg::OFS_MAT_HI:  mat_q     <= {wb_req_in.dat, latch_q};
            default:              ;
         endcase
      end
   end

   // Latch low writes, capture high on low read
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         latch_q <= 8'h00;
      else if (wr && (wb_req_in.adr == tkp_pkg::OFS_LATCH || wb_req_in.adr == tkp_pkg::OFS_CNT_LO
                      || wb_req_in.adr == tkp_pkg::OFS_TOP_LO
                      || wb_req_in.adr == tkp_pkg::OFS_MAT_LO))
         latch_q <= wb_req_in.dat;
      else if (rd && wb_req_in.adr == tkp_pkg::OFS_CNT_LO)
         latch_q <= cnt_q[15:8];
      else if (rd && wb_req_in.adr == tkp_pkg::OFS_TOP_LO)
         latch_q <= top_q[15:8];
      else if (rd && wb_req_in.adr == tkp_pkg::OFS_MAT_LO)
         latch_q <= mat_q[15:8];
   end

   // ----------------------------------------------------------------
   // Timekeeping source
   // ----------------------------------------------------------------
   tkp_edge_sync #(
      .W (3)
   ) u_src_sync (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .lane_in    ({crystal_input_pin_in, watch_crystal_osc_in, slow_internal_osc_in}),
      .rise_out   (rise)
   );

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         slow_div_q <= 5'h00;
      else if (rise[0])
         slow_div_q <= slow_div_q + 5'h01;
   end

   // Shared by counter and tick timer
   always_comb
   begin
      case (tkp_pkg::tkp_src_t'(src_q))
         tkp_pkg::SRC_SLOW_OSC:   src_tick = rise[0];
         tkp_pkg::SRC_SLOW_DIV:   src_tick = rise[0] && slow_div_q == tkp_pkg::SLOW_DIV_LAST;
         tkp_pkg::SRC_WATCH_XTAL: src_tick = rise[1];
         tkp_pkg::SRC_PIN:        src_tick = rise[2];
         default:                 src_tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Write synchronisation into the timekeeping ticks
   // ----------------------------------------------------------------
   always_comb
   begin
      sync_wr                   = '0;
      sync_wr[tkp_pkg::SY_CTRL] = wr && wb_req_in.adr == tkp_pkg::OFS_CTRL;
      sync_wr[tkp_pkg::SY_CNT]  = wr && wb_req_in.adr == tkp_pkg::OFS_CNT_HI;
      sync_wr[tkp_pkg::SY_TOP]  = wr && wb_req_in.adr == tkp_pkg::OFS_TOP_HI;
      sync_wr[tkp_pkg::SY_MAT]  = wr && wb_req_in.adr == tkp_pkg::OFS_MAT_HI;
      sync_wr[tkp_pkg::SY_TICK] = wr && wb_req_in.adr == tkp_pkg::OFS_TCTRL;
      for (int i = 0; i < tkp_pkg::SY_N; i++)
      begin
         busy[i]   = sync_cnt_q[i] != 2'h0;
         commit[i] = src_tick && !sync_wr[i] && sync_cnt_q[i] == 2'h1;
      end
   end

   // Busy holds for two source ticks; new write restarts
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < tkp_pkg::SY_N; i++)
            sync_cnt_q[i] <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < tkp_pkg::SY_N; i++)
         begin
            if (sync_wr[i])
               sync_cnt_q[i] <= tkp_pkg::SYNC_TICKS;
            else if (src_tick && busy[i])
               sync_cnt_q[i] <= sync_cnt_q[i] - 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_act_q  <= 8'h00;
         top_act_q   <= tkp_pkg::TOP_RESET;
         mat_act_q   <= 16'h0000;
         tctrl_act_q <= 8'h00;
      end
      else
      begin
         if (commit[tkp_pkg::SY_CTRL])
            ctrl_act_q <= ctrl_q;
         if (commit[tkp_pkg::SY_TOP])
            top_act_q <= top_q;
         if (commit[tkp_pkg::SY_MAT])
            mat_act_q <= mat_q;
         if (commit[tkp_pkg::SY_TICK])
            tctrl_act_q <= tctrl_q;
      end
   end

   // ----------------------------------------------------------------
   // Counter function
   // ----------------------------------------------------------------
   // Halt without debug bit, standby without run bit, or off stop it
   assign run = ctrl_act_q[tkp_pkg::CTRL_ON_BIT]
                && !(sleep_standby_in && !ctrl_act_q[tkp_pkg::CTRL_STBY_BIT])
                && !(cpu_halted_in && !dbg_q);
   // Divide by two to the prescaler field
   assign presc_mask = 15'((16'h0001 << ctrl_act_q[tkp_pkg::CTRL_PRESC_LSB +: 4]) - 16'h0001);
   assign step       = run && src_tick && (presc_q & presc_mask) == presc_mask;
   // Flagged on the count after equality
   assign wrap_hit   = step && cnt_q == top_act_q;
   assign match_hit  = step && cnt_q == mat_act_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         presc_q <= 15'h0000;
      else if (!run)
         presc_q <= 15'h0000;
      else if (src_tick)
         presc_q <= presc_q + 15'h0001;
   end

   // Wrap clears the count; a committed write wins
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cnt_q <= 16'h0000;
      else if (commit[tkp_pkg::SY_CNT])
         cnt_q <= cnt_wr_q;
      else if (wrap_hit)
         cnt_q <= 16'h0000;
      else if (step)
         cnt_q <= cnt_q + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Tick timer
   // ----------------------------------------------------------------
   // No sleep gating, only off or debug halt
   assign trun = tctrl_act_q[tkp_pkg::TCTRL_ON_BIT] && !(cpu_halted_in && !tdbg_q);
   assign tper = tctrl_act_q[tkp_pkg::TCTRL_PER_LSB +: 4];
   assign tper_mask = 16'((17'h00002 << tper) - 17'h00001);
   assign tirq_hit  = trun && src_tick && tper >= tkp_pkg::TPER_MIN && tper <= tkp_pkg::TPER_MAX
                      && ({1'b0, tick_cnt_q} & tper_mask) == tper_mask;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         tick_cnt_q <= 15'h0000;
      else if (!tctrl_act_q[tkp_pkg::TCTRL_ON_BIT])
         tick_cnt_q <= 15'h0000;
      else if (trun && src_tick)
         tick_cnt_q <= tick_cnt_q + 15'h0001;
   end

   always_comb
   begin
      for (int k = 0; k < 8; k++)
         tick_evt[k] = trun && src_tick
                       && &(tick_cnt_q | ~15'((16'h0001 << (tkp_pkg::EVT_TOP_LOG2 - k)) - 1));
   end

   // ----------------------------------------------------------------
   // Flags, requests and events
   // ----------------------------------------------------------------
   // Set wins over a same-cycle write-one clear
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flag_q  <= 2'h0;
         tflag_q <= 1'b0;
      end
      else
      begin
         flag_q[tkp_pkg::FLG_WRAP] <= wrap_hit
            || (flag_q[tkp_pkg::FLG_WRAP]
                && !(wr && wb_req_in.adr == tkp_pkg::OFS_IRQ_FLG && wb_req_in.dat[0]));
         flag_q[tkp_pkg::FLG_MATCH] <= match_hit
            || (flag_q[tkp_pkg::FLG_MATCH]
                && !(wr && wb_req_in.adr == tkp_pkg::OFS_IRQ_FLG && wb_req_in.dat[1]));
         tflag_q <= tirq_hit
            || (tflag_q && !(wr && wb_req_in.adr == tkp_pkg::OFS_TIRQ_FL && wb_req_in.dat[0]));
      end
   end

   // Level request while flag and enable both set
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_tk_q   <= 1'b0;
         irq_tick_q <= 1'b0;
         vec_q      <= tkp_pkg::VEC_TIMEKEEPER;
      end
      else
      begin
         irq_tk_q   <= |(flag_q & irq_en_q);
         irq_tick_q <= tflag_q && tirq_en_q;
         vec_q      <= |(flag_q & irq_en_q) ? tkp_pkg::VEC_TIMEKEEPER
                       : (tflag_q && tirq_en_q) ? tkp_pkg::VEC_TICK : vec_q;
      end
   end

   // Hits already require the function running
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         evt_q <= '0;
      else
      begin
         evt_q.wrap  <= wrap_hit;
         evt_q.match <= match_hit;
         evt_q.tick  <= tick_evt;
      end
   end

   assign wb_rsp_out         = rsp_q;
   assign evt_out            = evt_q;
   assign irq_timekeeper_out = irq_tk_q;
   assign irq_tick_out       = irq_tick_q;
   assign irq_vector_out     = vec_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_WRAP_CLEARS: assert property (wrap_hit && !commit[1] |=> cnt_q == 16'h0000)
      else $error("Counter did not clear on wrap");
   AST_WRAP_FLAG: assert property (wrap_hit |=> flag_q[0] && evt_q.wrap)
      else $error("Wrap did not set flag and event");
   AST_MATCH_EVT: assert property (match_hit |=> evt_q.match && flag_q[1])
      else $error("Match did not raise event");
   AST_IRQ_LEVEL: assert property (1 |=> irq_timekeeper_out == $past(|(flag_q & irq_en_q)))
      else $error("Request not tied to flag and enable");
   AST_OFF_QUIET: assert property (!ctrl_act_q[0] |=> !evt_q.wrap && !evt_q.match)
      else $error("Counter event while disabled");
   AST_TICK_OFF_QUIET: assert property (!tctrl_act_q[0] |=> evt_q.tick == 8'h00 && !tirq_hit)
      else $error("Tick event while disabled");
   AST_CNT_BUSY: assert property (sync_wr[1] |=> busy[1] [*2])
      else $error("Count busy not held");
   AST_TICK_BUSY: assert property (sync_wr[4] |=> rd_dat[0] || wb_req_in.adr != 5'h11)
      else $error("Tick busy not shown");
   AST_LATCH_HIGH: assert property (rd && wb_req_in.adr == 5'h08 |=> latch_q == $past(cnt_q[15:8]))
      else $error("High byte not latched");
   AST_STANDBY_STOP: assert property (sleep_standby_in && !ctrl_act_q[7] |-> !step)
      else $error("Counter ran in standby");
   AST_ACK_ONE: assert property (rsp_q.ack |=> !rsp_q.ack)
      else $error("Ack held too long");

   COV_WRAP: cover property (wrap_hit ##1 irq_timekeeper_out);
   COV_TICK_IRQ: cover property (tirq_hit ##2 irq_tick_out);
   COV_CNT_COMMIT: cover property (sync_wr[1] ##[1:300] commit[1]);
endmodule

// File: verif/tkp_src_model.sv
// Purpose: Behavioural timekeeping sources seen by the block
// Assumes: Sources are far slower than the system clock
// Notes:   Lanes stand still at 0 while run is low
module tkp_src_model #(
   parameter int HALF = 4
) (
   input  wire logic       clk_sys_in,
   input  wire logic       run_in,
   output logic      [2:0] lane_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always_ff @(posedge clk_sys_in)
   begin
      if (!run_in)
      begin
         cnt      <= 0;
         lane_out <= 3'h0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt      <= 0;
         lane_out <= ~lane_out;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

// File: verif/tb_tkp_timekeeper.sv
// Purpose: Self-checking bench for the timekeeper block
// Assumes: Source tick every 8 system cycles
// Notes:   Debug halt held inactive; standby driven once
module tb_tkp_timekeeper;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk_sys_in;
   logic                 rst_n_in;
   logic                 irq_tk;
   logic                 irq_tick;
   logic [7:0]           vec;
   logic [2:0]           lanes;
   logic [7:0]           q;
   logic [7:0]           a;
   logic                 sleep_sb;
   int                   nw;
   int                   n_ev;
   int                   e0;
   int                   n_errors;
   int                   comparisons;
   tkp_pkg::tkp_wb_req_t req;
   tkp_pkg::tkp_wb_rsp_t rsp;
   tkp_pkg::tkp_evt_t    evt;
   tkp_src_model tkp_src_model_inst (.clk_sys_in(clk_sys_in), .run_in(rst_n_in), .lane_out(lanes));
   tkp_timekeeper tkp_timekeeper_inst (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_req_in(req), .wb_rsp_out(rsp),
      .slow_internal_osc_in(lanes[0]), .watch_crystal_osc_in(lanes[1]),
      .crystal_input_pin_in(lanes[2]), .sleep_standby_in(sleep_sb), .cpu_halted_in(1'b0),
      .irq_timekeeper_out(irq_tk), .irq_tick_out(irq_tick), .irq_vector_out(vec), .evt_out(evt));
   always @(posedge clk_sys_in)
      if (evt.wrap | evt.match)
         n_ev++;
   task automatic final_report();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // -------------------------------------------------------------
   // Bus cycle: entered and left just after a rising edge
   // -------------------------------------------------------------
   task automatic bus(input logic we, input logic [4:0] adr, input logic [7:0] dat);
      int n;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 1'b1, adr: adr, dat: dat};
      n = 0;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (rsp.ack !== 1'b1 && n < 50);
      q = rsp.dat;
      req <= '0;
      @(posedge clk_sys_in);
      if (n == 50)
      begin
         n_errors++;
         final_report();
      end
   endtask
   task automatic rd(input logic [4:0] adr, input logic [7:0] exp);
      bus(1'b0, adr, 8'h00);
      chk(q, exp);
   endtask
   task automatic wait_for(input int which);
      for (int n = 0; n < 3000; n++)
      begin
         @(posedge clk_sys_in);
         nw = n;
         if ((which == 0 && evt.wrap) || (which == 1 && irq_tick) || (which == 2 && evt.tick[7]))
            return;
      end
      n_errors++;
      final_report();
   endtask
   // Software waits out pending syncs before tracked writes
   task automatic settle();
      for (int n = 0; n < 100; n++)
      begin
         bus(1'b0, tkp_pkg::OFS_STAT, 8'h00);
         a = q;
         bus(1'b0, tkp_pkg::OFS_TSTAT, 8'h00);
         if ((a | q) === 8'h00)
            return;
      end
      n_errors++;
      final_report();
   endtask
   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial
   begin
      rst_n_in = 1'b0;
      req = '0;
      sleep_sb = 1'b0;
      n_ev = 0;
      n_errors = 0;
      comparisons = 0;
      repeat (12) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(tkp_pkg::OFS_CTRL, 8'h00);
      rd(tkp_pkg::OFS_TOP_LO, 8'hFF);
      rd(tkp_pkg::OFS_LATCH, 8'hFF);
      rd(5'h06, 8'h00);
      bus(1'b1, tkp_pkg::OFS_CTRL, 8'h01);
      rd(tkp_pkg::OFS_STAT, 8'h01);
      settle();
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b1, tkp_pkg::OFS_SRC, 8'(s));
         bus(1'b0, tkp_pkg::OFS_CNT_LO, 8'h00);
         a = q;
         repeat (600) @(posedge clk_sys_in);
         bus(1'b0, tkp_pkg::OFS_CNT_LO, 8'h00);
         chk(8'(a !== q), 8'h01);
      end
      // Standby without the run bit freezes the count
      sleep_sb <= 1'b1;
      bus(1'b0, tkp_pkg::OFS_CNT_LO, 8'h00);
      a = q;
      repeat (200) @(posedge clk_sys_in);
      rd(tkp_pkg::OFS_CNT_LO, a);
      sleep_sb <= 1'b0;
      bus(1'b1, tkp_pkg::OFS_CTRL, 8'h00);
      settle();
      bus(1'b1, tkp_pkg::OFS_SRC, 8'h00);
      bus(1'b0, tkp_pkg::OFS_CNT_LO, 8'h00);
      a = q;
      e0 = n_ev;
      repeat (200) @(posedge clk_sys_in);
      rd(tkp_pkg::OFS_CNT_LO, a);
      chk(8'(n_ev - e0), 8'h00);
      rd(tkp_pkg::OFS_IRQ_FLG, 8'h02);
      chk(8'(irq_tk), 8'h00);
      bus(1'b1, tkp_pkg::OFS_TOP_LO, 8'h03);
      bus(1'b1, tkp_pkg::OFS_TOP_HI, 8'h00);
      settle();
      bus(1'b1, tkp_pkg::OFS_MAT_LO, 8'h01);
      bus(1'b1, tkp_pkg::OFS_MAT_HI, 8'h00);
      // Count must start below top, or the wrap is 64k steps away
      bus(1'b1, tkp_pkg::OFS_CNT_LO, 8'h00);
      bus(1'b1, tkp_pkg::OFS_CNT_HI, 8'h00);
      settle();
      bus(1'b1, tkp_pkg::OFS_IRQ_EN, 8'h03);
      bus(1'b1, tkp_pkg::OFS_IRQ_FLG, 8'h03);
      bus(1'b1, tkp_pkg::OFS_CTRL, 8'h09);
      wait_for(0);
      wait_for(0);
      // Prescale 2 x four steps x 8-cycle ticks = 64 cycles per wrap
      chk(8'(nw), 8'h3F);
      rd(tkp_pkg::OFS_IRQ_FLG, 8'h03);
      chk(8'(irq_tk), 8'h01);
      chk(vec, 8'h00);
      bus(1'b1, tkp_pkg::OFS_CTRL, 8'h00);
      settle();
      bus(1'b1, tkp_pkg::OFS_IRQ_FLG, 8'h01);
      rd(tkp_pkg::OFS_IRQ_FLG, 8'h02);
      chk(8'(irq_tk), 8'h01);
      bus(1'b1, tkp_pkg::OFS_IRQ_EN, 8'h01);
      chk(8'(irq_tk), 8'h00);
      rd(tkp_pkg::OFS_IRQ_FLG, 8'h02);
      bus(1'b1, tkp_pkg::OFS_TIRQ_EN, 8'h01);
      bus(1'b1, tkp_pkg::OFS_TCTRL, 8'h09);
      rd(tkp_pkg::OFS_TSTAT, 8'h01);
      wait_for(1);
      chk(vec, 8'h02);
      wait_for(2);
      wait_for(2);
      // Event 7 every 64 ticks of 8 cycles: 0x1FF edges apart
      chk(8'(nw), 8'hFF);
      chk(8'(nw >> 8), 8'h01);
      bus(1'b1, tkp_pkg::OFS_TCTRL, 8'h00);
      settle();
      bus(1'b1, tkp_pkg::OFS_TIRQ_FL, 8'h01);
      chk(8'(irq_tick), 8'h00);
      final_report();
   end
endmodule
